/* hdl/instr_exec.v */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "instr_exec_defines.vh"

module instr_exec #(
  parameter PC_W = 11,
  parameter STACK_DEPTH = 4,
  parameter MEM_DEPTH = 128,
  parameter WDT_PRESCALE = `WDT_PRESCALE
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Power-down clock gate request
  output reg clock_stop
);

  // One-hot sequencer states, binary watchdog pre-clear states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_EXEC = 4'b0010;
  localparam [3:0] ST_DUMMY = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;
  localparam [1:0] PRE_NONE = 2'd0;
  localparam [1:0] PRE_FIRST = 2'd1;
  localparam [1:0] PRE_SECOND = 2'd2;

  reg [3:0] state_reg;
  reg [31:0] cmd_reg;
  reg [PC_W-1:0] target_reg;
  reg [7:0] acc_reg;
  reg [PC_W-1:0] pc_reg;
  reg [6:0] maddr_reg;
  reg [7:0] watchdog_counter;
  reg [15:0] prescale_reg;
  reg carry_flag;
  reg nibble_out_flag;
  reg null_flag;
  reg signed_wrap_flag;
  reg watchdog_expired_flag;
  reg sleep_entry_flag;
  reg global_irq_gate;
  reg irq_pending_reg;
  reg [1:0] preclear_last_reg;
  reg [1:0] sp_reg;
  reg [7:0] dmem [0:MEM_DEPTH-1];
  reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];

  // Decoded command fields
  wire [5:0] op = cmd_reg[`CMD_OP_MSB:`CMD_OP_LSB];
  wire [7:0] imm = cmd_reg[`CMD_IMM_MSB:`CMD_IMM_LSB];
  wire [6:0] maddr = cmd_reg[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  wire [2:0] bit_sel = cmd_reg[`CMD_BIT_MSB:`CMD_BIT_LSB];
  wire [7:0] mem_rd = (maddr == `PCL_ADDR) ? pc_reg[7:0] : dmem[maddr];
  wire [7:0] sw_mem_rd = (maddr_reg == `PCL_ADDR) ? pc_reg[7:0] : dmem[maddr_reg];
  wire [1:0] sp_dec = sp_reg - 2'd1;
  wire [PC_W-1:0] pc_inc = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire is_idle = state_reg[0];
  wire irq_take = is_idle & irq_pending_reg & global_irq_gate;
  reg addr_ok;
  reg busy_refuse;

  always @* begin
    case (paddr)
      `OFS_CMD, `OFS_TARGET, `OFS_ACC, `OFS_STATUS, `OFS_PC,
      `OFS_MADDR, `OFS_MDATA, `OFS_WDT, `OFS_IRQ: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Writes that would race the datapath are refused while busy
  always @* begin
    busy_refuse = 1'b0;
    if (pwrite && (!is_idle || irq_take)) begin
      case (paddr)
        `OFS_CMD, `OFS_ACC, `OFS_STATUS, `OFS_MDATA: busy_refuse = 1'b1;
        default: busy_refuse = 1'b0;
      endcase
    end
  end

  assign pready = penable;
  assign pslverr = apb_access & (~addr_ok | busy_refuse);
  wire wr_ok = apb_access & pwrite & addr_ok & ~busy_refuse;

  // Datapath results
  reg [7:0] opnd;
  reg [8:0] sum9;
  reg [4:0] low5;
  reg [7:0] res;
  reg to_acc;
  reg to_mem;
  reg upd_null;
  reg upd_add;
  reg upd_carry_only;
  reg [8:0] daa9;

  always @* begin
    opnd = (op == `OP_ADD_X || op == `OP_AND_X || op == `OP_OR_X) ? imm : mem_rd;
    // 8-bit add with carry and nibble carry
    sum9 = {1'b0, acc_reg} + {1'b0, opnd};
    low5 = {1'b0, acc_reg[3:0]} + {1'b0, opnd[3:0]};
    daa9 = {1'b0, acc_reg} + {1'b0, ((acc_reg[7:4] > 4'h9) || carry_flag) ? 4'h6 : 4'h0,
      ((acc_reg[3:0] > 4'h9) || nibble_out_flag) ? 4'h6 : 4'h0};
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_null = 1'b0;
    upd_add = 1'b0;
    upd_carry_only = 1'b0;
    case (op)
      `OP_ADD_M, `OP_ADD_X: begin
        res = sum9[7:0]; to_acc = 1'b1; upd_add = 1'b1;
      end
      `OP_ADD_INTO_M: begin
        res = sum9[7:0]; to_mem = 1'b1; upd_add = 1'b1;
      end
      `OP_AND_M, `OP_AND_X: begin
        res = acc_reg & opnd; to_acc = 1'b1; upd_null = 1'b1;
      end
      `OP_AND_INTO_M: begin
        res = acc_reg & opnd; to_mem = 1'b1; upd_null = 1'b1;
      end
      `OP_OR_M, `OP_OR_X: begin
        res = acc_reg | opnd; to_acc = 1'b1; upd_null = 1'b1;
      end
      `OP_OR_INTO_M: begin
        res = acc_reg | opnd; to_mem = 1'b1; upd_null = 1'b1;
      end
      `OP_CLR_M: begin
        res = 8'h00; to_mem = 1'b1;
      end
      `OP_CLR_BIT: begin
        res = mem_rd & ~(8'h01 << bit_sel); to_mem = 1'b1;
      end
      `OP_CPL: begin
        res = ~mem_rd; to_mem = 1'b1; upd_null = 1'b1;
      end
      `OP_COMPLEMENT_TO_ACCUMULATOR: begin
        res = ~mem_rd; to_acc = 1'b1; upd_null = 1'b1;
      end
      `OP_DAA: begin
        res = daa9[7:0]; to_mem = 1'b1; upd_carry_only = 1'b1;
      end
      `OP_DEC: begin
        res = mem_rd - 8'h01; to_mem = 1'b1; upd_null = 1'b1;
      end
      `OP_DECREMENT_TO_ACCUMULATOR: begin
        res = mem_rd - 8'h01; to_acc = 1'b1; upd_null = 1'b1;
      end
      `OP_INC: begin
        res = mem_rd + 8'h01; to_mem = 1'b1; upd_null = 1'b1;
      end
      `OP_INCREMENT_TO_ACCUMULATOR: begin
        res = mem_rd + 8'h01; to_acc = 1'b1; upd_null = 1'b1;
      end
      `OP_MOV_AM: begin
        res = mem_rd; to_acc = 1'b1;
      end
      `OP_MOV_MA: begin
        res = acc_reg; to_mem = 1'b1;
      end
      `OP_MOV_AX, `OP_RET_AX: begin
        res = imm; to_acc = 1'b1;
      end
      // rotate left, bit 7 into bit 0
      `OP_RL: begin
        res = {mem_rd[6:0], mem_rd[7]}; to_mem = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  wire pcl_write = to_mem && (maddr == `PCL_ADDR);
  wire is_branch = (op == `OP_CALL) || (op == `OP_JMP) || (op == `OP_RET) ||
    (op == `OP_RET_AX) || (op == `OP_RETURN_FROM_INTERRUPT);
  wire wd_clear_now = (op == `OP_WD_CLR) ||
    (op == `OP_WD_PRE1 && preclear_last_reg == PRE_SECOND) ||
    (op == `OP_WD_PRE2 && preclear_last_reg == PRE_FIRST);
  wire prescale_tick = (prescale_reg == WDT_PRESCALE[15:0] - 16'd1);
  // Expiry in the same cycle beats a clear
  wire wdt_expire = !state_reg[3] && prescale_tick && (watchdog_counter == 8'hFF);

  // Register read data, captured in the setup cycle
  always @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        `OFS_CMD: prdata <= cmd_reg;
        `OFS_TARGET: prdata <= {{(32-PC_W){1'b0}}, target_reg};
        `OFS_ACC: prdata <= {24'h000000, acc_reg};
        `OFS_STATUS: prdata <= {22'h000000, state_reg[3], ~is_idle, 1'b0,
          global_irq_gate, sleep_entry_flag, watchdog_expired_flag,
          signed_wrap_flag, null_flag, nibble_out_flag, carry_flag};
        `OFS_PC: prdata <= {{(32-PC_W){1'b0}}, pc_reg};
        `OFS_MADDR: prdata <= {25'h0000000, maddr_reg};
        `OFS_MDATA: prdata <= {24'h000000, sw_mem_rd};
        `OFS_WDT: prdata <= {24'h000000, watchdog_counter};
        `OFS_IRQ: prdata <= {31'h00000000, irq_pending_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Data memory and stack writes
  always @(posedge clock) begin
    if (state_reg[1] && to_mem && !pcl_write)
      dmem[maddr] <= res;
    else if (wr_ok && paddr == `OFS_MDATA && maddr_reg != `PCL_ADDR)
      dmem[maddr_reg] <= pwdata[7:0];
    if (state_reg[1] && op == `OP_CALL)
      stack_mem[sp_reg] <= pc_inc;
    // interrupt entry saves the resume address
    else if (irq_take)
      stack_mem[sp_reg] <= pc_reg;
  end

  // Sequencer, flags, watchdog
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 32'h00000000;
      target_reg <= {PC_W{1'b0}};
      acc_reg <= 8'h00;
      pc_reg <= `PC_RESET;
      maddr_reg <= 7'h00;
      watchdog_counter <= 8'h00;
      prescale_reg <= 16'h0000;
      carry_flag <= 1'b0;
      nibble_out_flag <= 1'b0;
      null_flag <= 1'b0;
      signed_wrap_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      sleep_entry_flag <= 1'b0;
      global_irq_gate <= 1'b0;
      irq_pending_reg <= 1'b0;
      preclear_last_reg <= PRE_NONE;
      sp_reg <= 2'd0;
      clock_stop <= 1'b0;
    end else begin
      // Watchdog runs from a prescaler enable, frozen in sleep
      if (!state_reg[3]) begin
        prescale_reg <= prescale_tick ? 16'h0000 : prescale_reg + 16'd1;
        if (prescale_tick) begin
          watchdog_counter <= watchdog_counter + 8'h01;
          if (watchdog_counter == 8'hFF)
            watchdog_expired_flag <= 1'b1;
        end
      end
      // Software register writes
      if (wr_ok) begin
        case (paddr)
          `OFS_TARGET: target_reg <= pwdata[PC_W-1:0];
          `OFS_ACC: acc_reg <= pwdata[7:0];
          `OFS_MADDR: maddr_reg <= pwdata[6:0];
          `OFS_STATUS: begin
            carry_flag <= pwdata[`ST_CARRY];
            nibble_out_flag <= pwdata[`ST_NIBBLE];
            null_flag <= pwdata[`ST_NULL];
            signed_wrap_flag <= pwdata[`ST_WRAP];
            global_irq_gate <= pwdata[`ST_GATE];
          end
          `OFS_IRQ: irq_pending_reg <= pwdata[0];
          `OFS_CMD: begin
            cmd_reg <= pwdata;
            state_reg <= ST_EXEC;
          end
          default: begin
          end
        endcase
      end
      case (state_reg)
        ST_IDLE: begin
          if (irq_take) begin
            sp_reg <= sp_reg + 2'd1;
            pc_reg <= `IRQ_VECTOR;
            global_irq_gate <= 1'b0;
            // A request raised in this cycle stays pending
            irq_pending_reg <= wr_ok && (paddr == `OFS_IRQ) && pwdata[0];
            state_reg <= ST_DUMMY;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_IDLE;
          pc_reg <= pc_inc;
          if (to_acc)
            acc_reg <= res;
          if (upd_null || upd_add)
            null_flag <= (res == 8'h00);
          if (upd_add) begin
            carry_flag <= sum9[8];
            nibble_out_flag <= low5[4];
            signed_wrap_flag <= (acc_reg[7] == opnd[7]) && (sum9[7] != acc_reg[7]);
          end
          if (upd_carry_only)
            carry_flag <= daa9[8] | carry_flag;
          if (pcl_write) begin
            pc_reg <= {pc_reg[PC_W-1:8], res};
            state_reg <= ST_DUMMY;
          end
          if (op == `OP_JMP || op == `OP_CALL)
            pc_reg <= target_reg;
          if (op == `OP_CALL)
            sp_reg <= sp_reg + 2'd1;
          if (op == `OP_RET || op == `OP_RET_AX || op == `OP_RETURN_FROM_INTERRUPT) begin
            pc_reg <= stack_mem[sp_dec];
            sp_reg <= sp_dec;
          end
          if (op == `OP_RETURN_FROM_INTERRUPT)
            global_irq_gate <= 1'b1;
          if (is_branch)
            state_reg <= ST_DUMMY;
          if (op == `OP_WD_PRE1)
            preclear_last_reg <= (preclear_last_reg == PRE_SECOND) ? PRE_NONE : PRE_FIRST;
          if (op == `OP_WD_PRE2)
            preclear_last_reg <= (preclear_last_reg == PRE_FIRST) ? PRE_NONE : PRE_SECOND;
          if (wd_clear_now) begin
            watchdog_counter <= 8'h00;
            watchdog_expired_flag <= wdt_expire;
            sleep_entry_flag <= 1'b0;
          end
          if (op == `OP_HALT) begin
            watchdog_counter <= 8'h00;
            prescale_reg <= 16'h0000;
            watchdog_expired_flag <= wdt_expire;
            sleep_entry_flag <= 1'b1;
            clock_stop <= 1'b1;
            state_reg <= ST_SLEEP;
          end
        end
        ST_DUMMY: begin
          state_reg <= ST_IDLE;
        end
        ST_SLEEP: begin
          // Wake on an interrupt request
          if (irq_pending_reg) begin
            clock_stop <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

/* shared/instr_exec_defines.vh */
`ifndef INSTR_EXEC_DEFINES_VH
`define INSTR_EXEC_DEFINES_VH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_TARGET 8'h04
`define OFS_ACC 8'h08
`define OFS_STATUS 8'h0C
`define OFS_PC 8'h10
`define OFS_MADDR 8'h14
`define OFS_MDATA 8'h18
`define OFS_WDT 8'h1C
`define OFS_IRQ 8'h20

// Command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 5
`define CMD_IMM_LSB 8
`define CMD_IMM_MSB 15
`define CMD_ADDR_LSB 16
`define CMD_ADDR_MSB 22
`define CMD_BIT_LSB 24
`define CMD_BIT_MSB 26

// Status bit positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_NULL 2
`define ST_WRAP 3
`define ST_EXPIRED 4
`define ST_SLEEP 5
`define ST_GATE 6
`define ST_BUSY 8
`define ST_HALTED 9

// Data memory address that aliases the program counter low byte
`define PCL_ADDR 7'h06

// Opcodes
`define OP_NOP 6'h00
`define OP_ADD_M 6'h01
`define OP_ADD_X 6'h02
`define OP_ADD_INTO_M 6'h03
`define OP_AND_M 6'h04
`define OP_AND_X 6'h05
`define OP_AND_INTO_M 6'h06
`define OP_OR_M 6'h07
`define OP_OR_X 6'h08
`define OP_OR_INTO_M 6'h09
`define OP_CALL 6'h0A
`define OP_CLR_M 6'h0B
`define OP_CLR_BIT 6'h0C
`define OP_WD_CLR 6'h0D
`define OP_WD_PRE1 6'h0E
`define OP_WD_PRE2 6'h0F
`define OP_CPL 6'h10
`define OP_COMPLEMENT_TO_ACCUMULATOR 6'h11
`define OP_DAA 6'h12
`define OP_DEC 6'h13
`define OP_DECREMENT_TO_ACCUMULATOR 6'h14
`define OP_INC 6'h15
`define OP_INCREMENT_TO_ACCUMULATOR 6'h16
`define OP_HALT 6'h17
`define OP_JMP 6'h18
`define OP_MOV_AM 6'h19
`define OP_MOV_MA 6'h1A
`define OP_MOV_AX 6'h1B
`define OP_RET 6'h1C
`define OP_RET_AX 6'h1D
`define OP_RETURN_FROM_INTERRUPT 6'h1E
`define OP_RL 6'h1F

// Reset address, interrupt vector and default watchdog prescale
`define PC_RESET 11'h000
`define IRQ_VECTOR 11'h004
`define WDT_PRESCALE 256

`endif

/* bench/clock_gate_model.sv */
`timescale 1ns/1ns
module clock_gate_model (
  // Core clock and gate request
  input wire clock,
  input wire clock_stop,
  // Edges seen by the gated domain
  output int gated_edges
);
  initial gated_edges = 0;
  always @(posedge clock) begin
    if (!clock_stop) begin
      gated_edges <= gated_edges + 1;
    end
  end
endmodule

/* bench/instr_exec_assertions.sv */
`timescale 1ns/1ns
`include "instr_exec_defines.vh"
module instr_exec_assertions (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Power-down clock gate request
  input wire clock_stop
);
  // Access decodes
  wire acc_cyc = psel && penable;
  wire cmd_wr = acc_cyc && pwrite && paddr == `OFS_CMD;
  wire cmd_ok = cmd_wr && !pslverr;
  wire irq_set = acc_cyc && pwrite && paddr == `OFS_IRQ && pwdata[0];
  wire unmapped = paddr > `OFS_IRQ;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_ready_follows;
    pready == penable;
  endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("pready not penable");
  property p_err_in_access;
    pslverr |-> acc_cyc;
  endproperty
  a_err_in_access: assert property (p_err_in_access) else $error("pslverr outside access");
  property p_unmapped_err;
    acc_cyc && unmapped |-> pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not refused");
  property p_unmapped_zero;
    acc_cyc && !pwrite && unmapped |-> prdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
  property p_halt_stops;
    cmd_ok && pwdata[5:0] == `OP_HALT |-> ##[1:3] clock_stop;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("no clock stop after halt");
  property p_wake_cause;
    $fell(clock_stop) |-> $past(irq_set) || $past(irq_set, 2) || $past(irq_set, 3);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without request");
  property p_branch_busy;
    cmd_ok && (pwdata[5:0] == `OP_JMP || pwdata[5:0] == `OP_CALL) ##2 cmd_wr |-> pslverr;
  endproperty
  a_branch_busy: assert property (p_branch_busy) else $error("dummy slot accepted");
  property p_single_cycle;
    cmd_ok && pwdata[5:0] == `OP_NOP ##2 cmd_wr |-> !pslverr;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("one-cycle op busy");
endmodule
bind instr_exec instr_exec_assertions i_instr_exec_assertions (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_stop(clock_stop));

/* bench/tb_instr_exec.sv */
`timescale 1ns/1ns
`include "instr_exec_defines.vh"
module tb_instr_exec;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, bb = 0, err;
  logic [7:0] paddr = 0, a, m, im;
  logic [31:0] pwdata = 0, q;
  wire [31:0] prdata;
  wire pready, pslverr, clock_stop;
  int n_fail = 0, n_checks = 0, gated_edges, g0;
  logic [3:0] f;
  logic [6:0] ad;
  logic [2:0] bt;
  logic [8:0] r;
  logic [10:0] pc = 0, t;
  logic [10:0] stk[$];
  logic [5:0] ops[23] = '{`OP_NOP, `OP_ADD_M, `OP_ADD_X, `OP_ADD_INTO_M, `OP_AND_M, `OP_AND_X,
    `OP_AND_INTO_M, `OP_OR_M, `OP_OR_X, `OP_OR_INTO_M, `OP_CLR_M, `OP_CLR_BIT, `OP_CPL,
    `OP_COMPLEMENT_TO_ACCUMULATOR, `OP_DAA, `OP_DEC, `OP_DECREMENT_TO_ACCUMULATOR, `OP_INC, `OP_INCREMENT_TO_ACCUMULATOR, `OP_MOV_AM, `OP_MOV_MA,
    `OP_MOV_AX, `OP_RL};
  // Clock source
  always #5 clock = ~clock;
  instr_exec #(.WDT_PRESCALE(2)) i_instr_exec (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_stop(clock_stop));
  clock_gate_model i_clock_gate_model (.clock(clock), .clock_stop(clock_stop),
    .gated_edges(gated_edges));
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer; bb keeps psel up for a back-to-back follower
  task apb(input logic w, input logic [7:0] ad_, input logic [31:0] wd);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad_;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) chk(pready, 1);
    q = prdata;
    err = pslverr;
    if (!bb) begin
      psel <= 0;
      penable <= 0;
      @(posedge clock);
    end
  endtask
  task wr(input logic [7:0] ad_, input logic [31:0] wd); apb(1, ad_, wd); endtask
  task rdchk(input logic [7:0] ad_, input logic [31:0] exp, input logic [31:0] mk = '1);
    apb(0, ad_, 0);
    chk(q & mk, exp);
  endtask
  // Poll busy until the instruction retires
  task idle;
    for (int k = 0; k < 20; k++) begin
      apb(0, `OFS_STATUS, 0);
      if (q[8] === 1'b0) break;
    end
    if (q[8] !== 1'b0) chk(q[8], 0);
  endtask
  task cmd(input logic [5:0] op);
    wr(`OFS_CMD, {5'h0, bt, 1'b0, ad, im, 2'h0, op});
    idle;
  endtask
  // Reference datapath
  task model(input logic [5:0] op);
    logic [7:0] b;
    b = (op == `OP_ADD_X || op == `OP_AND_X || op == `OP_OR_X) ? im : m;
    r = 9'h0;
    case (op)
      `OP_ADD_M, `OP_ADD_X, `OP_ADD_INTO_M: begin
        r = a + b;
        f[0] = r[8];
        f[1] = (a[3:0] + b[3:0]) > 15;
        f[3] = (a[7] == b[7]) && (r[7] != a[7]);
      end
      `OP_AND_M, `OP_AND_X, `OP_AND_INTO_M: r = a & b;
      `OP_OR_M, `OP_OR_X, `OP_OR_INTO_M: r = a | b;
      `OP_CLR_BIT: r = m & ~(8'h01 << bt);
      `OP_CPL, `OP_COMPLEMENT_TO_ACCUMULATOR: r = ~m;
      `OP_DAA: begin
        r = a + ((a[3:0] > 9 || f[1]) ? 8'h06 : 8'h00) + ((a[7:4] > 9 || f[0]) ? 8'h60 : 8'h00);
        f[0] = f[0] | r[8];
      end
      `OP_DEC, `OP_DECREMENT_TO_ACCUMULATOR: r = m - 1;
      `OP_INC, `OP_INCREMENT_TO_ACCUMULATOR: r = m + 1;
      `OP_MOV_AM: r = m;
      `OP_MOV_MA: r = a;
      `OP_MOV_AX: r = im;
      `OP_RL: r = {m[6:0], m[7]};
      default: r = 9'h0;
    endcase
    if (op inside {[`OP_ADD_M:`OP_OR_INTO_M], `OP_CPL, `OP_COMPLEMENT_TO_ACCUMULATOR, [`OP_DEC:`OP_INCREMENT_TO_ACCUMULATOR]})
      f[2] = r[7:0] == 0;
    if (op inside {`OP_ADD_INTO_M, `OP_AND_INTO_M, `OP_OR_INTO_M, `OP_CLR_M, `OP_CLR_BIT,
      `OP_CPL, `OP_DAA, `OP_DEC, `OP_INC, `OP_MOV_MA, `OP_RL}) m = r[7:0];
    else if (op != `OP_NOP && op != `OP_CLR_M) a = r[7:0];
    pc = pc + 1;
  endtask
  // Main sequence
  initial begin
    void'($urandom(93809));
    repeat (4) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (int i = 0; i < 69; i++) begin
      a = $urandom;
      m = $urandom;
      im = $urandom;
      f = $urandom;
      bt = $urandom;
      ad = 8 + $urandom % 120;
      wr(`OFS_ACC, {24'h0, a});
      wr(`OFS_STATUS, {28'h0, f});
      wr(`OFS_MADDR, {25'h0, ad});
      wr(`OFS_MDATA, {24'h0, m});
      cmd(ops[i % 23]);
      model(ops[i % 23]);
      rdchk(`OFS_ACC, {24'h0, a});
      rdchk(`OFS_STATUS, {28'h0, f}, 32'hF);
      rdchk(`OFS_MDATA, {24'h0, m});
      rdchk(`OFS_PC, {21'h0, pc});
    end
    $display("Test datapath operations done");
    ad = `PCL_ADDR;
    bb = 1;
    wr(`OFS_CMD, {5'h0, bt, 1'b0, ad, im, 2'h0, `OP_MOV_MA});
    bb = 0;
    wr(`OFS_CMD, {26'h0, `OP_NOP});
    chk(err, 1);
    idle;
    pc = {pc[10:8], a};
    rdchk(`OFS_PC, {21'h0, pc});
    t = $urandom;
    bb = 1;
    wr(`OFS_TARGET, {21'h0, t});
    wr(`OFS_CMD, {26'h0, `OP_JMP});
    bb = 0;
    wr(`OFS_CMD, {26'h0, `OP_NOP});
    chk(err, 1);
    idle;
    pc = t;
    rdchk(`OFS_PC, {21'h0, pc});
    bb = 1;
    wr(`OFS_CMD, {26'h0, `OP_NOP});
    bb = 0;
    wr(`OFS_CMD, {26'h0, `OP_NOP});
    chk(err, 0);
    idle;
    pc = pc + 2;
    for (int j = 0; j < 3; j++) begin
      t = $urandom;
      im = $urandom;
      wr(`OFS_TARGET, {21'h0, t});
      cmd(`OP_CALL);
      stk.push_back(pc + 1);
      pc = t;
      rdchk(`OFS_PC, {21'h0, pc});
      cmd(j == 0 ? `OP_RET : j == 1 ? `OP_RET_AX : `OP_RETURN_FROM_INTERRUPT);
      pc = stk.pop_back();
      if (j == 1) a = im;
      rdchk(`OFS_PC, {21'h0, pc});
      rdchk(`OFS_ACC, {24'h0, a});
      rdchk(`OFS_STATUS, {25'h0, j == 2, 2'b00, f}, 32'h4F);
    end
    $display("Test branches done");
    wr(`OFS_IRQ, 1);
    idle;
    idle;
    stk.push_back(pc);
    rdchk(`OFS_PC, 32'h4);
    wr(`OFS_IRQ, 1);
    cmd(`OP_RETURN_FROM_INTERRUPT);
    idle;
    rdchk(`OFS_PC, 32'h4);
    cmd(`OP_RETURN_FROM_INTERRUPT);
    pc = stk.pop_back();
    rdchk(`OFS_PC, {21'h0, pc});
    rdchk(`OFS_STATUS, 32'h40, 32'h40);
    wr(`OFS_STATUS, {28'h0, f});
    $display("Test interrupt return done");
    wr(`OFS_CMD, {26'h0, `OP_HALT});
    @(posedge clock);
    chk(clock_stop, 1);
    rdchk(`OFS_STATUS, 32'h220, 32'h230);
    g0 = gated_edges;
    repeat (10) @(posedge clock);
    chk(gated_edges - g0, 0);
    wr(`OFS_IRQ, 1);
    idle;
    chk(clock_stop, 0);
    wr(`OFS_IRQ, 0);
    $display("Test power-down done");
    repeat (600) @(posedge clock);
    rdchk(`OFS_STATUS, 32'h30, 32'h30);
    cmd(`OP_WD_PRE1);
    cmd(`OP_WD_PRE1);
    rdchk(`OFS_STATUS, 32'h30, 32'h30);
    cmd(`OP_WD_PRE2);
    rdchk(`OFS_STATUS, 32'h0, 32'h30);
    repeat (600) @(posedge clock);
    rdchk(`OFS_STATUS, 32'h10, 32'h10);
    cmd(`OP_WD_CLR);
    rdchk(`OFS_STATUS, 32'h0, 32'h30);
    apb(0, `OFS_WDT, 0);
    chk(q < 8, 1);
    apb(0, 8'h40, 0);
    chk(q, 0);
    chk(err, 1);
    $display("Test watchdog and decode done");
    close_out;
  end
  // Hang guard
  initial begin
    #500000;
    n_fail++;
    close_out;
  end
endmodule
